/* verilog/imr_map.vh */
// Register offsets, field positions and reset values of the mask block.
`ifndef IMR_MAP_VH
`define IMR_MAP_VH
`define IMR_AW 8
`define IMR_DW 16
`define IMR_GROUP_OFS 8'h20
`define IMR_EVENT_OFS 8'h21
`define IMR_STAT_OFS 8'h1F
// Writable bits and reset values of the group mask.
`define IMR_GROUP_IMPL 16'h33FF
`define IMR_GROUP_RST 16'h33FF
// Writable bits and reset values of the charger and clock mask.
`define IMR_EVENT_IMPL 16'hFEE7
`define IMR_EVENT_RST 16'h0000
// Group positions inside the group mask.
`define IMR_G_CHARGER 2
`define IMR_G_CLOCK 4
`define IMR_G_WAKEUP 0
`define IMR_G_EXTCMP 8
`define IMR_G_AUDIO 7
`define IMR_G_OVERCURRENT 13
`define IMR_G_UNDERVOLT 12
`define IMR_G_SINK 9
`define IMR_G_PIN 6
`define IMR_G_AUXCONV 5
`define IMR_G_SYSTEM 3
`define IMR_G_USB 1
// Field positions inside the charger and clock mask.
`define IMR_E_HOT 15
`define IMR_E_COLD 14
`define IMR_E_FAIL 13
`define IMR_E_TIMEOUT 12
`define IMR_E_END 11
`define IMR_E_START 10
`define IMR_E_FAST 9
`define IMR_E_PERIODIC 7
`define IMR_E_SECOND 6
`define IMR_E_ALARM 5
`define IMR_E_BHIGH 2
`define IMR_E_BMID 1
`define IMR_E_BLOW 0
// Event sources that feed the charger and the clock groups.
`define IMR_CHARGER_SEL 16'hFE07
`define IMR_CLOCK_SEL 16'h00E0
// Mask used for flags that carry no individual mask.
`define IMR_NO_MASK 16'h0000
// Event-status register bits: wakeup causes on 6..0.
`define IMR_WAKE_MASK 16'h007F
// Comparator and jack-detect bits on 15..13 and 11..8.
`define IMR_BOTH_MASK 16'hEF00
`define IMR_EXT_MASK 16'hE000
`define IMR_AUD_MASK 16'h0F00
`endif

/* verilog/imr_mask_regs.v */
// Two-level interrupt mask registers with an event status register.
`timescale 1ns/1ps
`include "imr_map.vh"
// How it works
// [RULE1] A mask bit at one blocks its source; zero lets it through.
// [RULE2] Group mask at 20h resets bits 13, 12, 9..0 to one.
// [RULE3] Event mask at 21h resets to zero on charger, clock, battery bits.
// [RULE4] Power state machine reset restores every mask to default.
// [RULE5] Reading the status register clears its event flags.
// [RULE6] Wakeup flags set on rising edge; comparator, jack on both edges.
// [RULE7] Request asserts when an unmasked group holds an unmasked set flag.
module imr_mask_regs (
   input wire ref_clk, // System clock, 20 MHz.
   input wire sys_rst, // State machine reset, active high.
   input wire [7:0] reg_addr, // Register address.
   input wire [15:0] reg_wdata, // Write data.
   input wire reg_wr, // Write strobe.
   input wire reg_rd, // Read strobe.
   output reg [15:0] reg_rdata, // Read data, valid the cycle after reg_rd.
   input wire [15:0] evt_level, // Raw status conditions from pins.
   input wire [15:0] chg_clk_events, // Charger and clock event flags.
   input wire [15:0] group_pending, // Other groups' pending status.
   output reg irq_q // Interrupt request, active high.
);

   reg [15:0] group_mask_q;
   reg [15:0] event_mask_q;
   reg [15:0] stat_q;
   reg [15:0] lvl_s1_q;
   reg [15:0] lvl_s2_q;
   reg [15:0] lvl_old_q;
   reg [15:0] stat_d;
   reg [15:0] group_raw;
   wire [15:0] edges;
   wire stat_rd;

   // Named views of the group mask fields.
   wire mask_overcurrent_group;
   wire mask_undervoltage_group;
   wire mask_current_sink_group;
   wire mask_external_comparator_group;
   wire mask_audio_group;
   wire mask_pin_group;
   wire mask_aux_converter_group;
   wire mask_clock_group;
   wire mask_system_group;
   wire mask_charger_group;
   wire mask_usb_group;
   wire mask_wakeup_group;
   // Named views of the charger and clock mask fields.
   wire mask_battery_hot;
   wire mask_battery_cold;
   wire mask_battery_fail;
   wire mask_charge_timeout;
   wire mask_charge_end;
   wire mask_charge_start;
   wire mask_fast_charge_ready;
   wire mask_clock_periodic;
   wire mask_clock_second;
   wire mask_clock_alarm;
   wire mask_battery_below_high;
   wire mask_battery_below_mid;
   wire mask_battery_below_low;
   wire [15:0] group_mask_f;
   wire [15:0] event_mask_f;
   reg [15:0] group_open;

   ////////////////////////////////////////////////////////////////////////
   // True when any selected flag is set with its mask bit clear.
   function any_open;
      input [15:0] flags;
      input [15:0] mask;
      input [15:0] sel;
      begin
         any_open = |(flags & ~mask & sel);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Group mask fields.
   assign mask_overcurrent_group = group_mask_q[`IMR_G_OVERCURRENT];
   assign mask_undervoltage_group = group_mask_q[`IMR_G_UNDERVOLT];
   assign mask_current_sink_group = group_mask_q[`IMR_G_SINK];
   assign mask_external_comparator_group = group_mask_q[`IMR_G_EXTCMP];
   assign mask_audio_group = group_mask_q[`IMR_G_AUDIO];
   assign mask_pin_group = group_mask_q[`IMR_G_PIN];
   assign mask_aux_converter_group = group_mask_q[`IMR_G_AUXCONV];
   assign mask_clock_group = group_mask_q[`IMR_G_CLOCK];
   assign mask_system_group = group_mask_q[`IMR_G_SYSTEM];
   assign mask_charger_group = group_mask_q[`IMR_G_CHARGER];
   assign mask_usb_group = group_mask_q[`IMR_G_USB];
   assign mask_wakeup_group = group_mask_q[`IMR_G_WAKEUP];

   // Charger and clock mask fields.
   assign mask_battery_hot = event_mask_q[`IMR_E_HOT];
   assign mask_battery_cold = event_mask_q[`IMR_E_COLD];
   assign mask_battery_fail = event_mask_q[`IMR_E_FAIL];
   assign mask_charge_timeout = event_mask_q[`IMR_E_TIMEOUT];
   assign mask_charge_end = event_mask_q[`IMR_E_END];
   assign mask_charge_start = event_mask_q[`IMR_E_START];
   assign mask_fast_charge_ready = event_mask_q[`IMR_E_FAST];
   assign mask_clock_periodic = event_mask_q[`IMR_E_PERIODIC];
   assign mask_clock_second = event_mask_q[`IMR_E_SECOND];
   assign mask_clock_alarm = event_mask_q[`IMR_E_ALARM];
   assign mask_battery_below_high = event_mask_q[`IMR_E_BHIGH];
   assign mask_battery_below_mid = event_mask_q[`IMR_E_BMID];
   assign mask_battery_below_low = event_mask_q[`IMR_E_BLOW];

   // Fields reassembled; unimplemented positions stay zero.
   assign group_mask_f = {2'h0, mask_overcurrent_group,
      mask_undervoltage_group, 2'h0, mask_current_sink_group,
      mask_external_comparator_group, mask_audio_group, mask_pin_group,
      mask_aux_converter_group, mask_clock_group, mask_system_group,
      mask_charger_group, mask_usb_group, mask_wakeup_group};
   assign event_mask_f = {mask_battery_hot, mask_battery_cold,
      mask_battery_fail, mask_charge_timeout, mask_charge_end,
      mask_charge_start, mask_fast_charge_ready, 1'h0,
      mask_clock_periodic, mask_clock_second, mask_clock_alarm, 2'h0,
      mask_battery_below_high, mask_battery_below_mid,
      mask_battery_below_low};

   ////////////////////////////////////////////////////////////////////////
   // Level conditions come from pins and are synchronised first.
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         lvl_s1_q <= 16'h0000;
         lvl_s2_q <= 16'h0000;
         lvl_old_q <= 16'h0000;
      end else begin
         lvl_s1_q <= evt_level;
         lvl_s2_q <= lvl_s1_q;
         lvl_old_q <= lvl_s2_q;
      end
   end

   // [RULE6] Edge selection per flag.
   assign edges = ((lvl_s2_q & ~lvl_old_q) & `IMR_WAKE_MASK) |
                  ((lvl_s2_q ^ lvl_old_q) & `IMR_BOTH_MASK);

   assign stat_rd = reg_rd && (reg_addr == `IMR_STAT_OFS);

   // [RULE5] Clear on read; a new edge in the same cycle wins.
   always @* begin
      stat_d = stat_q;
      if (stat_rd) begin
         stat_d = 16'h0000;
      end
      stat_d = stat_d | edges;
   end

   ////////////////////////////////////////////////////////////////////////
   // Mask registers and status flags.
   always @(posedge ref_clk) begin
      // [RULE4] State machine reset restores defaults.
      if (sys_rst) begin
         // [RULE2] Group defaults to masked.
         group_mask_q <= `IMR_GROUP_RST;
         // [RULE3] Event masks default clear.
         event_mask_q <= `IMR_EVENT_RST;
         stat_q <= 16'h0000;
      end else begin
         stat_q <= stat_d;
         if (reg_wr && reg_addr == `IMR_GROUP_OFS) begin
            group_mask_q <= reg_wdata & `IMR_GROUP_IMPL;
         end
         if (reg_wr && reg_addr == `IMR_EVENT_OFS) begin
            event_mask_q <= reg_wdata & `IMR_EVENT_IMPL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero.
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `IMR_GROUP_OFS: reg_rdata <= group_mask_q;
            `IMR_EVENT_OFS: reg_rdata <= event_mask_q;
            `IMR_STAT_OFS: reg_rdata <= stat_q;
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Group pending terms from local flags and external groups.
   always @* begin
      group_raw = group_pending;

      // [RULE1] Charger sources gated by their own masks.
      group_raw[`IMR_G_CHARGER] = group_pending[`IMR_G_CHARGER] |
         any_open(chg_clk_events, event_mask_f, `IMR_CHARGER_SEL);

      // [RULE1] Clock sources gated by their own masks.
      group_raw[`IMR_G_CLOCK] = group_pending[`IMR_G_CLOCK] |
         any_open(chg_clk_events, event_mask_f, `IMR_CLOCK_SEL);

      // Wakeup, comparator and jack flags carry no individual mask here.
      group_raw[`IMR_G_WAKEUP] = group_pending[`IMR_G_WAKEUP] |
         any_open(stat_q, `IMR_NO_MASK, `IMR_WAKE_MASK);

      group_raw[`IMR_G_EXTCMP] = group_pending[`IMR_G_EXTCMP] |
         any_open(stat_q, `IMR_NO_MASK, `IMR_EXT_MASK);

      group_raw[`IMR_G_AUDIO] = group_pending[`IMR_G_AUDIO] |
         any_open(stat_q, `IMR_NO_MASK, `IMR_AUD_MASK);
   end

   // [RULE1] Group masks gate whole groups.
   always @* begin
      group_open = group_raw & ~group_mask_f & `IMR_GROUP_IMPL;
   end

   // [RULE7] Request from unmasked groups.
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |group_open;
      end
   end

endmodule // imr_mask_regs

/* dv/imr_host.sv */
// Host model that drives the register port.
`timescale 1ns/1ps
module imr_host (
   input wire ref_clk, // Clock.
   output reg [7:0] reg_addr = 8'h00, // Address.
   output reg [15:0] reg_wdata = 16'h0000, // Write data.
   output reg reg_wr = 1'h0, // Write strobe.
   output reg reg_rd = 1'h0 // Read strobe.
);
   task acc(input w, input [7:0] a, input [15:0] d);
      @(posedge ref_clk) #1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
      @(posedge ref_clk) #1;
      {reg_wr, reg_rd} = 2'h0;
   endtask
endmodule // imr_host

/* dv/imr_mask_regs_assertions.sv */
// Port assertions for the mask block.
`timescale 1ns/1ps
module imr_chk (
   input wire ref_clk, // Clock.
   input wire sys_rst, // Reset.
   input wire [7:0] reg_addr, // Address.
   input wire [15:0] reg_wdata, // Write data.
   input wire reg_wr, // Write strobe.
   input wire reg_rd, // Read strobe.
   input wire [15:0] reg_rdata, // Read data.
   input wire [15:0] evt_level, // Raw conditions.
   input wire [15:0] chg_clk_events, // Charger and clock flags.
   input wire [15:0] group_pending, // Other groups.
   input wire irq_q // Interrupt request.
);
   default clocking @(posedge ref_clk); endclocking
   sequence s_rd_group;
      !sys_rst && reg_rd && reg_addr == 8'h20;
   endsequence
   sequence s_rd_event;
      !sys_rst && reg_rd && reg_addr == 8'h21;
   endsequence
   sequence s_rd_unmapped;
      !sys_rst && reg_rd && reg_addr != 8'h1F && reg_addr != 8'h20 &&
         reg_addr != 8'h21;
   endsequence
   sequence s_reset_end;
      sys_rst ##1 !sys_rst;
   endsequence
   chk_reset_clear: assert property (sys_rst |=> !reg_rdata)
      else $error("Read data not cleared by reset.");
   chk_rd_hold: assert property (!reg_rd && !sys_rst |=> $stable(reg_rdata))
      else $error("Read data moved without a read.");
   chk_irq_reset: assert property (sys_rst |=> !irq_q)
      else $error("Request not cleared by reset.");
   chk_irq_quiet: assert property (s_reset_end |-> !irq_q ##1 !irq_q)
      else $error("Request raised while all groups masked.");
   chk_group_bits: assert property (s_rd_group |=> (reg_rdata & 16'hCC00) == 16'h0000)
      else $error("Group mask reads unimplemented bits.");
   chk_event_bits: assert property (s_rd_event |=> (reg_rdata & 16'h0118) == 16'h0000)
      else $error("Event mask reads unimplemented bits.");
   chk_unmapped_zero: assert property (s_rd_unmapped |=> reg_rdata == 16'h0000)
      else $error("Unmapped read not zero.");
endmodule // imr_chk
bind imr_mask_regs imr_chk imr_chk_i (
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .evt_level(evt_level),
   .chg_clk_events(chg_clk_events),
   .group_pending(group_pending),
   .irq_q(irq_q)
);

/* dv/tb.sv */
// Self-checking bench for the mask block.
`timescale 1ns/1ps
module tb;
   reg ref_clk = 1'h0;
   reg sys_rst = 1'h1;
   reg [15:0] evt_level = 16'h0000;
   reg [15:0] chg_clk_events = 16'hFEE7;
   reg [15:0] group_pending = 16'h0000;
   wire [15:0] reg_wdata, reg_rdata;
   wire [7:0] reg_addr;
   wire reg_wr, reg_rd, irq_q;
   integer bad_count = 0, checks = 0, seed = 3139, e;
   // Behavioural model of the three registers and the expected reads.
   integer m_group = 16'h33FF, m_event = 0, m_stat = 0, m_lvl = 0;
   integer exp_q[$];
   always #25 ref_clk = ~ref_clk;
   imr_host imr_host_i (.ref_clk(ref_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   imr_mask_regs imr_mask_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt_level(evt_level),
      .chg_clk_events(chg_clk_events), .group_pending(group_pending),
      .irq_q(irq_q));
   task cmp(input integer got, input integer exp);
      checks = checks + 1;
      bad_count = bad_count + (got !== exp);
      if (got !== exp) $display("BAD %0t %h %h", $time, got, exp);
   endtask
   task wr(input [7:0] a, input [15:0] d);
      if (a == 8'h20) m_group = d & 16'h33FF;
      if (a == 8'h21) m_event = d & 16'hFEE7;
      imr_host_i.acc(1'h1, a, d);
   endtask
   task rd(input [7:0] a);
      exp_q.push_back(a == 8'h20 ? m_group : a == 8'h21 ? m_event :
         a == 8'h1F ? m_stat : 0);
      if (a == 8'h1F) m_stat = 0;
      imr_host_i.acc(1'h0, a, 16'h0000);
      cmp(reg_rdata, exp_q.pop_front());
   endtask
   // Wakeup bits flag rising edges, comparator and jack bits both edges.
   task lvl(input [15:0] v);
      m_stat = m_stat | ((v & ~m_lvl) & 16'h007F) | ((v ^ m_lvl) & 16'hEF00);
      m_lvl = v;
      evt_level = v;
      repeat (5) @(posedge ref_clk) #1;
   endtask
   task print_verdict(input integer late);
      bad_count = bad_count + late;
      if (bad_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // The run needs about 44 cycles; the watchdog allows about nine times that.
   initial #20000 print_verdict(1);
   initial begin
      repeat (8) @(posedge ref_clk) #1;
      sys_rst = 1'h0;
      lvl(16'h0001);
      e = $random(seed);
      wr(8'h20, 16'h0001);
      wr(8'h21, e[15:0]);
      rd(8'h21);
      cmp(irq_q, |(chg_clk_events & ~m_event & 16'hFEE7));
      rd(8'h1F);
      rd(8'h1F);
      chg_clk_events = 16'h0000;
      lvl(16'h8001);
      cmp(irq_q, 1);
      rd(8'h1F);
      lvl(16'h0000);
      rd(8'h1F);
      rd(8'h22);
      sys_rst = 1'h1;
      m_group = 16'h33FF;
      m_event = 0;
      m_stat = 0;
      @(posedge ref_clk) #1 sys_rst = 1'h0;
      rd(8'h20);
      rd(8'h21);
      print_verdict(0);
   end
endmodule // tb
